/* src/pia_advert_defaults.sv */
// Purpose: Hard-reset value of the advertisement register from configuration bits
// Assumes: Configuration inputs come from logic on the same clock
// Notes: Select field maps one bit per speed and duplex ability
`timescale 1ns/100ps
module pia_advert_defaults import pia_pkg::*; (
   input wire logic flow_ctrl_advert_cfg_i,
   input wire logic [PIA_CAP_W-1:0] autoneg_select_cfg_i,
   output pia_reg_t advert_default_o
);

   always_comb begin
      advert_default_o = PIA_ADVERT_HW_RESET;
      advert_default_o[PIA_BIT_NEXT_PAGE] = 1'b0;
      advert_default_o[PIA_BIT_REMOTE_FAULT] = 1'b0;
      advert_default_o[PIA_BIT_PAUSE] = flow_ctrl_advert_cfg_i;
      advert_default_o[PIA_CAP_MSB:PIA_CAP_LSB] = autoneg_select_cfg_i;
      advert_default_o[PIA_SEL_MSB:0] = PIA_SELECTOR_8023;
      // Reserved and four-pair bits never leave zero
      advert_default_o = advert_default_o & ~PIA_ADVERT_ZERO_MASK;
   end

endmodule // pia_advert_defaults

/* src/pia_ident.sv */
// Purpose: Builds the 32-bit identity and splits it over two read-only words
// Assumes: Identity fields are fixed at elaboration
// Notes: Purely combinational; values are constants after elaboration
`timescale 1ns/100ps
module pia_ident import pia_pkg::*; #(
   // Arbitrary neutral identity values
   parameter logic [PIA_ORG_W-1:0] ORG_ID_BITS = 22'h0ABCDE,
   parameter logic [PIA_MODEL_W-1:0] MODEL_NUM = 6'h05,
   parameter logic [PIA_REV_W-1:0] REV_NUM = 4'h3,
   parameter bit IDENT_ZERO = 1'b0
) (
   output pia_ident_s ident_o,
   output logic [PIA_IDENT_W-1:0] ident_word_o
);

   logic [PIA_IDENT_W-1:0] full_ident;

   // Org bits first, then model, then revision
   assign full_ident = {ORG_ID_BITS, MODEL_NUM, REV_NUM};

   // A zero identity is allowed when the part should stay anonymous
   assign ident_word_o = IDENT_ZERO ? '0 : full_ident;

   // Org bits 3..18 land in the high word, the top two org bits are never stored
   assign ident_o.high = ident_word_o[PIA_IDENT_W-1 -: PIA_REG_W];
   // Org bits 19..24, model in 9:4, revision in 3:0
   assign ident_o.low = ident_word_o[PIA_REG_W-1:0];

endmodule // pia_ident

/* src/pia_pkg.sv */
// Purpose: Shared constants and carriers for the PHY identity and advertisement registers
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Registers are 16 bits wide in the low half of each word
package pia_pkg;

   localparam int PIA_DAT_W = 32;
   localparam int PIA_REG_W = 16;
   localparam int PIA_ADR_W = 8;
   localparam int PIA_SEL_W = PIA_DAT_W / 8;

   // Register byte offsets
   localparam logic [PIA_ADR_W-1:0] PIA_OFS_IDENT_HIGH = 8'h88;
   localparam logic [PIA_ADR_W-1:0] PIA_OFS_IDENT_LOW = 8'h8C;
   localparam logic [PIA_ADR_W-1:0] PIA_OFS_ADVERT = 8'h90;

   // Identity field widths, upper field first
   localparam int PIA_ORG_W = 22;
   localparam int PIA_ORG_HIGH_W = 16;
   localparam int PIA_MODEL_W = 6;
   localparam int PIA_REV_W = 4;
   localparam int PIA_IDENT_W = PIA_ORG_W + PIA_MODEL_W + PIA_REV_W;

   // Advertisement layout
   localparam logic [15:0] PIA_ADVERT_HW_RESET = 16'h05E1;
   localparam logic [15:0] PIA_ADVERT_WR_MASK = 16'hA5FF;
   localparam logic [15:0] PIA_ADVERT_ZERO_MASK = 16'h5A00;
   localparam int PIA_BIT_NEXT_PAGE = 15;
   localparam int PIA_BIT_RSVD_HI = 14;
   localparam int PIA_BIT_REMOTE_FAULT = 13;
   localparam int PIA_BIT_RSVD_MSB = 12;
   localparam int PIA_BIT_RSVD_LSB = 11;
   localparam int PIA_BIT_PAUSE = 10;
   localparam int PIA_BIT_FOUR_PAIR = 9;
   localparam int PIA_CAP_MSB = 8;
   localparam int PIA_CAP_LSB = 5;
   localparam int PIA_CAP_W = PIA_CAP_MSB - PIA_CAP_LSB + 1;
   localparam int PIA_SEL_MSB = 4;
   localparam logic [4:0] PIA_SELECTOR_8023 = 5'h01;

   typedef logic [PIA_REG_W-1:0] pia_reg_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [PIA_ADR_W-1:0] adr;
      logic [PIA_SEL_W-1:0] sel;
      logic [PIA_DAT_W-1:0] dat;
   } pia_wb_req_s;

   typedef struct packed {
      pia_reg_t high;
      pia_reg_t low;
   } pia_ident_s;

   typedef struct packed {
      logic ack;
      logic [PIA_DAT_W-1:0] rdata;
      pia_reg_t advert;
   } pia_state_s;

endpackage

/* src/pia_regs.sv */
// Purpose: Wishbone register bank for PHY identity and auto-negotiation advertisement
// Assumes: Classic Wishbone, one outstanding cycle, synchronous active-high reset
// Notes: ack comes one edge after the request; writes commit on the ack edge
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
module pia_regs import pia_pkg::*; #(
   // Arbitrary neutral identity values
   parameter logic [PIA_ORG_W-1:0] ORG_ID_BITS = 22'h0ABCDE,
   parameter logic [PIA_MODEL_W-1:0] MODEL_NUM = 6'h05,
   parameter logic [PIA_REV_W-1:0] REV_NUM = 4'h3,
   parameter bit IDENT_ZERO = 1'b0,
   parameter int ADR_W = PIA_ADR_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pia_wb_req_s wb_req_i,
   output logic [PIA_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic flow_ctrl_advert_cfg_i,
   input wire logic [PIA_CAP_W-1:0] autoneg_select_cfg_i,
   output pia_reg_t autoneg_advert_o,
   output logic [PIA_IDENT_W-1:0] phy_ident_o
);

   if (ADR_W != PIA_ADR_W) begin : g_adr_check
      $error("pia_regs: ADR_W must match the package address width");
   end
   if (PIA_IDENT_W != 2 * PIA_REG_W) begin : g_ident_check
      $error("pia_regs: identity must fill exactly two register words");
   end

   pia_state_s st;
   pia_state_s next_st;
   pia_ident_s ident;
   pia_reg_t advert_default;

   logic req;
   logic hit_high;
   logic hit_low;
   logic hit_advert;
   logic commit_wr;
   pia_reg_t wr_lanes;
   pia_reg_t wr_mask;
   pia_reg_t rd_val;

   pia_ident #(
      .ORG_ID_BITS(ORG_ID_BITS),
      .MODEL_NUM(MODEL_NUM),
      .REV_NUM(REV_NUM),
      .IDENT_ZERO(IDENT_ZERO)
   ) u_ident (
      .ident_o(ident),
      .ident_word_o(phy_ident_o)
   );

   pia_advert_defaults u_defaults (
      .flow_ctrl_advert_cfg_i(flow_ctrl_advert_cfg_i),
      .autoneg_select_cfg_i(autoneg_select_cfg_i),
      .advert_default_o(advert_default)
   );

   // Word decode; the two low address bits are lane bits and play no part
   function automatic logic word_hit(input logic [PIA_ADR_W-1:0] a,
                                     input logic [PIA_ADR_W-1:0] ofs);
      word_hit = (a[PIA_ADR_W-1:2] == ofs[PIA_ADR_W-1:2]);
   endfunction

   assign req = wb_req_i.cyc & wb_req_i.stb;
   assign hit_high = word_hit(wb_req_i.adr, PIA_OFS_IDENT_HIGH);
   assign hit_low = word_hit(wb_req_i.adr, PIA_OFS_IDENT_LOW);
   assign hit_advert = word_hit(wb_req_i.adr, PIA_OFS_ADVERT);

   // Write lands on the edge where the master sees ack, never earlier
   assign commit_wr = req & wb_req_i.we & st.ack & hit_advert;

   // Byte enables on the low two lanes; upper lanes carry nothing
   assign wr_lanes = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
   // Read-only and reserved bits are outside the mask, so writes never reach them
   assign wr_mask = wr_lanes & PIA_ADVERT_WR_MASK;

   // Read mux; unmapped offsets read zero and are still acknowledged
   always_comb begin
      rd_val = '0;
      if (hit_high) begin
         rd_val = ident.high;
      end else if (hit_low) begin
         rd_val = ident.low;
      end else if (hit_advert) begin
         rd_val = st.advert & ~PIA_ADVERT_ZERO_MASK;
      end
   end

   always_comb begin
      next_st = st;
      next_st.ack = req & ~st.ack;
      if (req & ~st.ack) begin
         next_st.rdata = {{(PIA_DAT_W - PIA_REG_W){1'b0}}, rd_val};
      end
      if (commit_wr) begin
         next_st.advert = (st.advert & ~wr_mask)
            | (wb_req_i.dat[PIA_REG_W-1:0] & wr_mask);
      end
      if (rst_i) begin
         next_st.ack = 1'b0;
         next_st.rdata = '0;
         // Configuration bits are sampled at the hard reset
         next_st.advert = advert_default;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.rdata;
   // Abilities seen by the negotiation engine never include reserved or four-pair
   assign autoneg_advert_o = st.advert & ~PIA_ADVERT_ZERO_MASK;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Helper copy of the advertisement before a given cycle
   pia_reg_t adv_prev;
   logic rst_prev;
   always_ff @(posedge clk_i) begin
      adv_prev <= st.advert;
      rst_prev <= rst_i;
   end

   sequence s_new_req;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   endsequence

   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   sequence s_rd_high;
      s_new_req and (hit_high && !wb_req_i.we);
   endsequence

   sequence s_rd_low;
      s_new_req and (hit_low && !wb_req_i.we);
   endsequence

   sequence s_rd_advert;
      s_new_req and (hit_advert && !wb_req_i.we);
   endsequence

   property p_ack_once;
      s_new_req |=> s_ack_pulse;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

   property p_ident_concat;
      phy_ident_o == {ident.high, ident.low};
   endproperty
   a_ident_concat: assert property (p_ident_concat) else $error("identity words mismatch");

   property p_ident_zero;
      IDENT_ZERO |-> (phy_ident_o == '0);
   endproperty
   a_ident_zero: assert property (p_ident_zero) else $error("identity not zero");

   property p_read_high;
      s_rd_high |=> (wb_ack_o && wb_dat_o == {16'h0000, phy_ident_o[PIA_IDENT_W-1 -: 16]});
   endproperty
   a_read_high: assert property (p_read_high) else $error("high identity read wrong");

   property p_read_low_org;
      s_rd_low |=> (wb_dat_o[15:10] == phy_ident_o[15:10]);
   endproperty
   a_read_low_org: assert property (p_read_low_org) else $error("org low bits wrong");

   property p_read_low_model;
      s_rd_low |=> (wb_dat_o[9:4] == MODEL_NUM || IDENT_ZERO);
   endproperty
   a_read_low_model: assert property (p_read_low_model) else $error("model number wrong");

   property p_read_low_rev;
      s_rd_low |=> (wb_dat_o[3:0] == REV_NUM || IDENT_ZERO);
   endproperty
   a_read_low_rev: assert property (p_read_low_rev) else $error("revision wrong");

   property p_read_advert;
      s_rd_advert |=> (wb_dat_o[15:0] == autoneg_advert_o && wb_dat_o[31:16] == 16'h0000);
   endproperty
   a_read_advert: assert property (p_read_advert) else $error("advert read wrong");

   // Reset value checked in the first cycle after release
   property p_reset_value;
      (rst_prev && !rst_i) |-> (st.advert[15:11] == 5'h00 && st.advert[9] == 1'b0
         && st.advert[4:0] == 5'h01);
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("advert reset wrong");

   property p_reset_cfg;
      (rst_prev && !rst_i) |-> (st.advert[10] == $past(flow_ctrl_advert_cfg_i)
         && st.advert[8:5] == $past(autoneg_select_cfg_i));
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("config defaults wrong");

   property p_reserved_zero;
      autoneg_advert_o[14] == 1'b0 && autoneg_advert_o[12:11] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_four_pair_zero;
      st.advert[9] == 1'b0 && autoneg_advert_o[9] == 1'b0;
   endproperty
   a_four_pair_zero: assert property (p_four_pair_zero) else $error("four-pair bit set");

   property p_write_commit;
      (commit_wr && wb_req_i.sel[1:0] == 2'b11) |=>
         (st.advert == ($past(wb_req_i.dat[15:0]) & PIA_ADVERT_WR_MASK));
   endproperty
   a_write_commit: assert property (p_write_commit) else $error("advert write lost");

   property p_fault_write;
      (commit_wr && wb_req_i.sel[1] && wb_req_i.dat[13]) |=> autoneg_advert_o[13];
   endproperty
   a_fault_write: assert property (p_fault_write) else $error("remote fault not set");

   property p_ro_write;
      (req && wb_req_i.we && wb_ack_o && !hit_advert) |=> (st.advert == adv_prev);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write had effect");

   property p_no_write_before_ack;
      (s_new_req and wb_req_i.we) |=> (st.advert == adv_prev);
   endproperty
   a_no_write_before_ack: assert property (p_no_write_before_ack) else $error("early write");

   property p_ident_stable;
      ##1 $stable(phy_ident_o);
   endproperty
   a_ident_stable: assert property (p_ident_stable) else $error("identity changed");

   // Bus-side sequences for the lane, unmapped-read and idle checks below
   sequence s_wr_both_lanes;
      commit_wr && wb_req_i.sel[1:0] == 2'b11;
   endsequence

   sequence s_wr_lane0;
      commit_wr && wb_req_i.sel[1:0] == 2'b01;
   endsequence

   sequence s_wr_lane1;
      commit_wr && wb_req_i.sel[1:0] == 2'b10;
   endsequence

   sequence s_rd_unmapped;
      s_new_req and (!hit_high && !hit_low && !hit_advert && !wb_req_i.we);
   endsequence

   sequence s_idle;
      !(wb_req_i.cyc && wb_req_i.stb);
   endsequence

   property p_ack_after_req;
      wb_ack_o |-> ($past(req) && !$past(wb_ack_o));
   endproperty
   a_ack_after_req: assert property (p_ack_after_req) else $error("ack without request");

   property p_idle_no_ack;
      s_idle |=> !wb_ack_o;
   endproperty
   a_idle_no_ack: assert property (p_idle_no_ack) else $error("ack while idle");

   property p_dat_upper_zero;
      wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000);
   endproperty
   a_dat_upper_zero: assert property (p_dat_upper_zero) else $error("upper read data set");

   // Read data must not move between taken requests
   property p_rdata_hold;
      !(req && !wb_ack_o) |=> $stable(wb_dat_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

   property p_read_unmapped;
      s_rd_unmapped |=> (wb_ack_o && wb_dat_o == 32'h0000_0000);
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read set");

   // Only a committed advertisement write may move the store
   property p_advert_hold;
      !commit_wr |=> $stable(st.advert);
   endproperty
   a_advert_hold: assert property (p_advert_hold) else $error("advert moved");

   // Lane 0 write leaves the upper byte alone
   property p_lane0_write;
      s_wr_lane0 |=> (st.advert[15:8] == adv_prev[15:8]
         && st.advert[7:0] == $past(wb_req_i.dat[7:0]));
   endproperty
   a_lane0_write: assert property (p_lane0_write) else $error("lane 0 wrong");

   // Lane 1 write leaves the lower byte alone
   property p_lane1_write;
      s_wr_lane1 |=> (st.advert[7:0] == adv_prev[7:0]
         && st.advert[15:8] == ($past(wb_req_i.dat[15:8]) & PIA_ADVERT_WR_MASK[15:8]));
   endproperty
   a_lane1_write: assert property (p_lane1_write) else $error("lane 1 wrong");

   property p_page_write;
      (commit_wr && wb_req_i.sel[1]) |=> (autoneg_advert_o[15] == $past(wb_req_i.dat[15]));
   endproperty
   a_page_write: assert property (p_page_write) else $error("next page lost");

   property p_pause_write;
      (commit_wr && wb_req_i.sel[1]) |=> (autoneg_advert_o[10] == $past(wb_req_i.dat[10]));
   endproperty
   a_pause_write: assert property (p_pause_write) else $error("pause bit lost");

   property p_cap_write;
      s_wr_both_lanes |=> (autoneg_advert_o[8:5] == $past(wb_req_i.dat[8:5]));
   endproperty
   a_cap_write: assert property (p_cap_write) else $error("ability bits lost");

   property p_selector_write;
      (commit_wr && wb_req_i.sel[0]) |=> (autoneg_advert_o[4:0] == $past(wb_req_i.dat[4:0]));
   endproperty
   a_selector_write: assert property (p_selector_write) else $error("selector lost");

   property p_fault_clear;
      (commit_wr && wb_req_i.sel[1] && !wb_req_i.dat[13]) |=> !autoneg_advert_o[13];
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("remote fault stuck");

   property p_rsvd_store_zero;
      s_wr_both_lanes |=> (st.advert[14] == 1'b0 && st.advert[12:11] == 2'b00
         && st.advert[9] == 1'b0);
   endproperty
   a_rsvd_store_zero: assert property (p_rsvd_store_zero) else $error("reserved stored");

   // First cycle after reset: no stale ack or read data
   property p_reset_bus;
      rst_prev |-> (!wb_ack_o && wb_dat_o == 32'h0000_0000);
   endproperty
   a_reset_bus: assert property (p_reset_bus) else $error("bus not quiet after reset");

endmodule // pia_regs

/* tb/tb_pia_regs.sv */
// Purpose: Self-checking bench for the identity and advertisement register bank
// Assumes: Classic Wishbone single cycles, ack and read data taken at the rising edge
// Notes: Config defaults are varied across several resets; identity values are arbitrary
`timescale 1ns/100ps
module tb_pia_regs import pia_pkg::*;;
   // Arbitrary neutral identity values
   localparam logic [PIA_ORG_W-1:0] ORG = 22'h2A5C3B;
   localparam logic [PIA_MODEL_W-1:0] MODEL = 6'h2D;
   localparam logic [PIA_REV_W-1:0] REV = 4'h9;
   logic clk_i;
   logic rst_i;
   pia_wb_req_s req;
   logic [PIA_DAT_W-1:0] wb_dat_o;
   logic wb_ack_o;
   logic pause_cfg;
   logic [PIA_CAP_W-1:0] sel_cfg;
   pia_reg_t autoneg_advert_o;
   logic [PIA_IDENT_W-1:0] phy_ident_o;
   logic [PIA_IDENT_W-1:0] zero_ident;
   logic [31:0] rd;
   int fail_count;
   int checks_done;

   pia_regs #(.ORG_ID_BITS(ORG), .MODEL_NUM(MODEL), .REV_NUM(REV)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .flow_ctrl_advert_cfg_i(pause_cfg), .autoneg_select_cfg_i(sel_cfg),
      .autoneg_advert_o(autoneg_advert_o), .phy_ident_o(phy_ident_o));

   // Second instance only to see the all-zero identity option
   pia_regs #(.ORG_ID_BITS(ORG), .MODEL_NUM(MODEL), .REV_NUM(REV), .IDENT_ZERO(1'b1)) DUT_ZERO (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(), .wb_ack_o(),
      .flow_ctrl_advert_cfg_i(pause_cfg), .autoneg_select_cfg_i(sel_cfg),
      .autoneg_advert_o(), .phy_ident_o(zero_ident));

   always #5 clk_i = ~clk_i;

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // Entered just after a rising edge; request held until the edge that shows ack
   task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat, output logic [31:0] data);
      int n;
      req.cyc <= 1'b1;
      req.stb <= 1'b1;
      req.we <= we;
      req.adr <= adr;
      req.sel <= sel;
      req.dat <= dat;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (n == 20) begin
         fail_count++;
         $display("unexpected ack at %h: expected 1 seen 0", adr);
         give_verdict();
      end else begin
         data = wb_dat_o;
      end
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      req.we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
      logic [31:0] dummy;
      bus(1'b1, adr, sel, dat, dummy);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 4'hF, 32'h0, rd);
      check(what, rd, exp);
   endtask

   task automatic do_reset(input logic p, input logic [3:0] s);
      rst_i <= 1'b1;
      pause_cfg <= p;
      sel_cfg <= s;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Full-default config last, so the closing default check sees it
   logic [4:0] cfg_tab [4] = '{5'h00, 5'h0A, 5'h15, 5'h1F};
   logic [15:0] exp_adv;

   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      req = '0;
      pause_cfg = 1'b1;
      sel_cfg = 4'hF;
      fail_count = 0;
      checks_done = 0;
      // Reset defaults for every tabled config; bits 15,14,13,12:11,9 stay zero
      foreach (cfg_tab[i]) begin
         do_reset(cfg_tab[i][4], cfg_tab[i][3:0]);
         exp_adv = {5'h00, cfg_tab[i][4], 1'b0, cfg_tab[i][3:0], 5'h01};
         pause_cfg <= ~cfg_tab[i][4];
         sel_cfg <= ~cfg_tab[i][3:0];
         rd_chk("advert reset", 8'h90, {16'h0, exp_adv});
         check("advert out", {16'h0, autoneg_advert_o}, {16'h0, exp_adv});
      end
      check("full default", {16'h0, autoneg_advert_o}, 32'h0000_05E1);
      $display("test advert reset done");

      rd_chk("ident high", 8'h88, {16'h0, ORG[21:6]});
      rd_chk("ident low", 8'h8C, {16'h0, ORG[5:0], MODEL, REV});
      check("ident word", phy_ident_o, {ORG, MODEL, REV});
      check("zero ident", zero_ident, 32'h0);
      wr(8'h88, 4'hF, 32'hFFFF_FFFF);
      wr(8'h8C, 4'hF, 32'h0000_0000);
      rd_chk("ident high kept", 8'h88, {16'h0, ORG[21:6]});
      rd_chk("ident low kept", 8'h8C, {16'h0, ORG[5:0], MODEL, REV});
      $display("test identity done");

      wr(8'h90, 4'hF, 32'h0000_E7FF);
      rd_chk("advert all ones", 8'h90, 32'h0000_A5FF);
      check("advert out ones", {16'h0, autoneg_advert_o}, 32'h0000_A5FF);
      wr(8'h90, 4'hF, 32'h0000_0000);
      rd_chk("advert all zero", 8'h90, 32'h0);
      wr(8'h90, 4'h1, 32'h0000_E7FF);
      rd_chk("advert low lane", 8'h90, 32'h0000_00FF);
      wr(8'h90, 4'h2, 32'h0000_E7FF);
      rd_chk("advert high lane", 8'h90, 32'h0000_A5FF);
      wr(8'h90, 4'hC, 32'h0000_0000);
      rd_chk("advert upper lanes", 8'h90, 32'h0000_A5FF);
      $display("test advert write done");

      rd_chk("unmapped read", 8'h94, 32'h0);
      wr(8'h94, 4'hF, 32'h0000_0000);
      rd_chk("advert after unmapped", 8'h90, 32'h0000_A5FF);
      do_reset(1'b1, 4'hF);
      rd_chk("advert second reset", 8'h90, 32'h0000_05E1);
      $display("test unmapped and rereset done");
      give_verdict();
   end
endmodule // tb_pia_regs
